// ---- shared/gpc_pkg.sv ----
// Purpose: Shared constants for the dual port general purpose I/O block.
// Assumes: Byte-wide register port, addresses as the core sees them.
// Notes: Offsets, field positions, reset values and widths live here once.
package gpc_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int PA_W = 6;
  localparam int PB_W = 8;
  localparam int CHG_W = 4;

  localparam logic [ADDR_W-1:0] OFS_BANK_A_DATA = 9'h0_005;
  localparam logic [ADDR_W-1:0] OFS_BANK_B_DATA = 9'h0_006;
  localparam logic [ADDR_W-1:0] OFS_BANK_B_DATA_ALT = 9'h0_106;
  localparam logic [ADDR_W-1:0] OFS_OPTION = 9'h0_081;
  localparam logic [ADDR_W-1:0] OFS_OPTION_ALT = 9'h0_181;
  localparam logic [ADDR_W-1:0] OFS_BANK_A_DIR = 9'h0_085;
  localparam logic [ADDR_W-1:0] OFS_BANK_B_DIR = 9'h0_086;
  localparam logic [ADDR_W-1:0] OFS_BANK_B_DIR_ALT = 9'h0_186;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL = 9'h0_00B;
  localparam logic [ADDR_W-1:0] OFS_CONVERTER_CONFIG = 9'h0_09F;
  localparam logic [ADDR_W-1:0] OFS_MISC_CONTROL = 9'h0_00F;

  localparam logic [DATA_W-1:0] RST_OPTION = 8'h00_FF;
  localparam logic [PA_W-1:0] RST_BANK_A_DIR = 6'h3F;
  localparam logic [PB_W-1:0] RST_BANK_B_DIR = 8'h00_FF;
  localparam logic [PA_W-1:0] RST_BANK_A_LATCH = 6'h00;
  localparam logic [PB_W-1:0] RST_BANK_B_LATCH = 8'h00_00;
  localparam logic [DATA_W-1:0] RST_CONVERTER_CONFIG = 8'h00_00;
  localparam logic RST_LVP = 1'b1;

  localparam int BIT_PULLUP_DISABLE_N = 7;
  localparam int BIT_EXT_IRQ_EDGE_SELECT = 6;
  localparam int BIT_CHANGE_IRQ_FLAG = 0;
  localparam int BIT_EXT_IRQ_FLAG = 1;
  localparam int BIT_CHANGE_IRQ_EN = 3;
  localparam int BIT_EXT_IRQ_EN = 4;
  localparam int BIT_LVP = 0;
  localparam int BIT_PROG_MODE_PIN = 3;
  localparam int BIT_OPEN_DRAIN_PIN = 4;
  localparam int BIT_EXT_IRQ_PIN = 0;
  localparam int CHG_LSB = 4;

  localparam logic [DATA_W-1:0] CONVERTER_CONFIG_MASK = 8'h00_CF;
  localparam logic [2:0] PCFG_ALL_DIGITAL = 3'h3;
  localparam logic [PA_W-1:0] ANALOG_CAPABLE = 6'h2F;
endpackage : gpc_pkg

// ---- shared/gpc_chg_if.sv ----
// Purpose: Carries the change detector signals between the port logic and the detector.
// Assumes: One clock domain, all signals level or one-cycle pulses on that clock.
// Notes: The port side owns pins, enables and strobes; the detector owns the flag.
interface gpc_chg_if #(parameter int WIDTH = 4);
  logic [WIDTH-1:0] pin_level;
  logic [WIDTH-1:0] compare_en;
  logic refresh;
  logic flag_clear;
  logic flag;
  logic [WIDTH-1:0] mismatch;

  modport port_side (output pin_level, output compare_en, output refresh, output flag_clear,
    input flag, input mismatch);
  modport detect_side (input pin_level, input compare_en, input refresh, input flag_clear,
    output flag, output mismatch);
endinterface : gpc_chg_if

// ---- verilog/gpc_change_detect.sv ----
// Purpose: Snapshot compare and sticky change flag for the upper port B pins.
// Assumes: Pins are synchronous to the clock.
// Notes: A mismatch keeps setting the flag until the snapshot is refreshed.
module gpc_change_detect
  import gpc_pkg::*;
#(
  parameter int WIDTH = CHG_W
)
(
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  gpc_chg_if.detect_side chg // Detector side of the change link.
);
  logic [WIDTH-1:0] snapshot;
  logic flag_q;
  logic next_flag;
  logic any_mismatch;

  // Outputs configured as outputs are masked out of the compare.
  assign chg.mismatch = (chg.pin_level ^ snapshot) & chg.compare_en; // see [RULE6] see [RULE7]
  assign any_mismatch = |chg.mismatch; // see [RULE8]
  // Set wins over a software clear in the same cycle.
  assign next_flag = any_mismatch | (flag_q & ~chg.flag_clear); // see [RULE11]
  assign chg.flag = flag_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      snapshot <= '0;
      flag_q <= 1'b0;
    end
    else
    begin
      if (chg.refresh)
      begin
        snapshot <= chg.pin_level; // see [RULE10]
      end
      flag_q <= next_flag;
    end
  end
endmodule : gpc_change_detect

// ---- verilog/gpc_port_top.sv ----
// Purpose: Two general purpose ports; port B has pull-ups, edge interrupt and change interrupt.
// Assumes: Pin inputs synchronous to REF_CLK; byte register port with one-cycle strobes.
// Notes: Output enables are active low; the pad combines them with the pull-up request.
// Operation
// [RULE1] Port B has eight bidirectional pins; direction one makes the pin an input.
// [RULE2] Direction zero drives the pin from its output latch.
// [RULE3] Clearing option bit 7 turns all port B pull-ups on together.
// [RULE4] A pin configured as output never has its pull-up on.
// [RULE5] Pull-ups are off after power-on reset.
// [RULE6] Only upper four input pins take part in change detection.
// [RULE7] Upper inputs are compared against a snapshot taken on port B reads.
// [RULE8] Mismatches are ORed into the change flag at control bit 0.
// [RULE9] A pending change interrupt wakes the device from sleep.
// [RULE10] Any port B read or write refreshes the snapshot, ending the mismatch.
// [RULE11] A lasting mismatch keeps setting the flag; software accesses port then clears.
// [RULE12] Software should not poll port B while using change detection.
// [RULE13] Port B bit 0 is an edge interrupt; option bit 6 picks the edge.
// [RULE14] Low-voltage programming is on by default and owns port B bit 3.
// [RULE15] Port A bit 4 is open drain; its input also feeds the timer clock.
// [RULE16] Unused upper bits of port A data and direction read zero.
// [RULE17] Slave-select serial use needs certain analog configuration field values.
// [RULE18] Data reads return pin levels; writes update only the latch.
// [RULE19] Port A direction follows the same convention as port B.
// [RULE20] After reset analog-capable port A pins are analog and read zero.
// [RULE21] Port B data, direction and option answer at both bank addresses.
module gpc_port_top
  import gpc_pkg::*;
#(
  parameter int PA_WIDTH = PA_W,
  parameter int PB_WIDTH = PB_W
)
(
  input wire logic REF_CLK, // System clock, 50 MHz.
  input wire logic SYS_RST, // Synchronous reset, active high.
  input wire logic [ADDR_W-1:0] REG_ADDR, // Register address.
  input wire logic [DATA_W-1:0] REG_WDATA, // Register write data.
  input wire logic REG_WR, // Write strobe.
  input wire logic REG_RD, // Read strobe.
  output logic [DATA_W-1:0] REG_RDATA, // Read data, valid the cycle after REG_RD.
  input wire logic [PA_WIDTH-1:0] PA_IN, // Port A pin levels.
  output logic [PA_WIDTH-1:0] PA_OUT, // Port A pin drive values.
  output logic [PA_WIDTH-1:0] PA_OE_N, // Port A drive enables, low drives.
  input wire logic [PB_WIDTH-1:0] PB_IN, // Port B pin levels.
  output logic [PB_WIDTH-1:0] PB_OUT, // Port B pin drive values.
  output logic [PB_WIDTH-1:0] PB_OE_N, // Port B drive enables, low drives.
  output logic [PB_WIDTH-1:0] PB_PULLUP, // Port B weak pull-up requests.
  output logic TIMER_CLK_IN, // Port A bit 4 level for the timer clock input.
  output logic PROG_PIN_IN, // Port B bit 3 level for the programming logic.
  output logic LVP_ACTIVE, // Low-voltage programming mode owns port B bit 3.
  input wire logic SLEEP_ACTIVE, // Core is in its low-power sleep state.
  output logic CHANGE_IRQ, // Change interrupt request, enabled and pending.
  output logic EXT_IRQ, // Edge interrupt request, enabled and pending.
  output logic WAKE // Wake request to the core while sleeping.
);
  // Register storage.
  logic [PA_WIDTH-1:0] latch_a;
  logic [PB_WIDTH-1:0] latch_b;
  logic [PA_WIDTH-1:0] dir_a;
  logic [PB_WIDTH-1:0] dir_b;
  logic [DATA_W-1:0] option_ctl;
  logic [DATA_W-1:0] conv_cfg;
  logic chg_en;
  logic ext_en;
  logic ext_flag;
  logic lvp_mode;
  logic ext_pin_prev;
  logic [DATA_W-1:0] rdata;

  // Address decode.
  logic sel_a_data;
  logic sel_b_data;
  logic sel_option;
  logic sel_a_dir;
  logic sel_b_dir;
  logic sel_irq;
  logic sel_conv;
  logic sel_misc;
  logic wr_a_data;
  logic wr_b_data;
  logic wr_option;
  logic wr_a_dir;
  logic wr_b_dir;
  logic wr_irq;
  logic wr_conv;
  logic wr_misc;

  // Pin level views and read values.
  logic [PA_WIDTH-1:0] analog_sel;
  logic [PA_WIDTH-1:0] pa_read;
  logic [PB_WIDTH-1:0] pb_read;
  logic [PB_WIDTH-1:0] pb_own;
  logic [DATA_W-1:0] irq_read;
  logic [DATA_W-1:0] next_rdata;
  logic pullups_on;
  logic ext_level;
  logic ext_edge;
  logic next_ext_flag;

  gpc_chg_if #(.WIDTH(CHG_W)) chg ();

  // Both bank addresses of port B data, direction and option reach the same storage.
  assign sel_a_data = (REG_ADDR == OFS_BANK_A_DATA);
  assign sel_b_data = (REG_ADDR == OFS_BANK_B_DATA) || (REG_ADDR == OFS_BANK_B_DATA_ALT); // see [RULE21]
  assign sel_option = (REG_ADDR == OFS_OPTION) || (REG_ADDR == OFS_OPTION_ALT); // see [RULE21]
  assign sel_a_dir = (REG_ADDR == OFS_BANK_A_DIR);
  assign sel_b_dir = (REG_ADDR == OFS_BANK_B_DIR) || (REG_ADDR == OFS_BANK_B_DIR_ALT); // see [RULE21]
  assign sel_irq = (REG_ADDR == OFS_IRQ_CONTROL);
  assign sel_conv = (REG_ADDR == OFS_CONVERTER_CONFIG);
  assign sel_misc = (REG_ADDR == OFS_MISC_CONTROL);

  // One write strobe per register, qualified by the shared write strobe.
  assign wr_a_data = REG_WR && sel_a_data;
  assign wr_b_data = REG_WR && sel_b_data;
  assign wr_option = REG_WR && sel_option;
  assign wr_a_dir = REG_WR && sel_a_dir;
  assign wr_b_dir = REG_WR && sel_b_dir;
  assign wr_irq = REG_WR && sel_irq;
  assign wr_conv = REG_WR && sel_conv;
  assign wr_misc = REG_WR && sel_misc;

  // Analog pins read zero unless the configuration field selects all digital.
  assign analog_sel = (conv_cfg[3:1] == PCFG_ALL_DIGITAL) ? '0 : ANALOG_CAPABLE; // see [RULE20]
  assign pa_read = PA_IN & ~analog_sel; // see [RULE18] see [RULE20]

  // Bit 3 belongs to the programming logic while low-voltage programming is on.
  assign pb_own = lvp_mode ? (8'h00_01 << BIT_PROG_MODE_PIN) : 8'h00_00; // see [RULE14]
  assign pb_read = PB_IN & ~pb_own; // see [RULE18]

  // Port A: direction one floats the pin, zero drives the latch.
  always_comb
  begin
    PA_OUT = latch_a; // see [RULE19]
    PA_OE_N = dir_a; // see [RULE19]
    // Open drain: only a low latch value is driven, a high one releases the pin.
    PA_OUT[BIT_OPEN_DRAIN_PIN] = 1'b0; // see [RULE15]
    PA_OE_N[BIT_OPEN_DRAIN_PIN] = dir_a[BIT_OPEN_DRAIN_PIN] | latch_a[BIT_OPEN_DRAIN_PIN]; // see [RULE15]
  end
  assign TIMER_CLK_IN = PA_IN[BIT_OPEN_DRAIN_PIN]; // see [RULE15]

  // Port B drive and pull-ups.
  assign PB_OUT = latch_b; // see [RULE2]
  assign PB_OE_N = dir_b | pb_own; // see [RULE1] see [RULE2] see [RULE14]
  assign pullups_on = ~option_ctl[BIT_PULLUP_DISABLE_N]; // see [RULE3]
  assign PB_PULLUP = {PB_WIDTH{pullups_on}} & dir_b & ~pb_own; // see [RULE3] see [RULE4]
  assign PROG_PIN_IN = PB_IN[BIT_PROG_MODE_PIN];
  assign LVP_ACTIVE = lvp_mode; // see [RULE14]

  // Change detector wiring: a port B access refreshes the snapshot.
  assign chg.pin_level = PB_IN[CHG_LSB +: CHG_W]; // see [RULE7]
  assign chg.compare_en = dir_b[CHG_LSB +: CHG_W]; // see [RULE6]
  assign chg.refresh = (REG_RD || REG_WR) && sel_b_data; // see [RULE7] see [RULE10]
  assign chg.flag_clear = wr_irq && !REG_WDATA[BIT_CHANGE_IRQ_FLAG]; // see [RULE11]

  gpc_change_detect #(.WIDTH(CHG_W)) u_change
  (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .chg(chg.detect_side)
  );

  // Edge interrupt on port B bit 0; edge select one means rising.
  assign ext_level = PB_IN[BIT_EXT_IRQ_PIN];
  assign ext_edge = option_ctl[BIT_EXT_IRQ_EDGE_SELECT] ? (ext_level && !ext_pin_prev)
    : (!ext_level && ext_pin_prev); // see [RULE13]
  // An edge in the cycle of a clear still sets the flag.
  assign next_ext_flag = ext_edge | (ext_flag & ~(wr_irq && !REG_WDATA[BIT_EXT_IRQ_FLAG]));

  // Interrupt requests and wake.
  assign CHANGE_IRQ = chg.flag && chg_en;
  assign EXT_IRQ = ext_flag && ext_en;
  assign WAKE = SLEEP_ACTIVE && (CHANGE_IRQ || EXT_IRQ); // see [RULE9]

  // Writing one to a flag bit leaves that flag unchanged; only a zero clears it.
  always_comb
  begin
    irq_read = '0;
    irq_read[BIT_CHANGE_IRQ_FLAG] = chg.flag; // see [RULE8]
    irq_read[BIT_EXT_IRQ_FLAG] = ext_flag;
    irq_read[BIT_CHANGE_IRQ_EN] = chg_en;
    irq_read[BIT_EXT_IRQ_EN] = ext_en;
  end

  // Read mux; unmapped addresses read zero.
  always_comb
  begin
    next_rdata = '0;
    if (sel_a_data)
    begin
      next_rdata = {{(DATA_W-PA_WIDTH){1'b0}}, pa_read}; // see [RULE16] see [RULE18]
    end
    else if (sel_b_data)
    begin
      next_rdata = pb_read; // see [RULE18]
    end
    else if (sel_option)
    begin
      next_rdata = option_ctl;
    end
    else if (sel_a_dir)
    begin
      next_rdata = {{(DATA_W-PA_WIDTH){1'b0}}, dir_a}; // see [RULE16]
    end
    else if (sel_b_dir)
    begin
      next_rdata = dir_b;
    end
    else if (sel_irq)
    begin
      next_rdata = irq_read;
    end
    else if (sel_conv)
    begin
      next_rdata = conv_cfg;
    end
    else if (sel_misc)
    begin
      next_rdata = {{(DATA_W-1){1'b0}}, lvp_mode};
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      rdata <= '0;
    end
    else if (REG_RD)
    begin
      rdata <= next_rdata;
    end
    else
    begin
      rdata <= '0;
    end
  end
  assign REG_RDATA = rdata;

  // Port latches: writes reach only the latch, never the pin read path.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      latch_a <= RST_BANK_A_LATCH;
      latch_b <= RST_BANK_B_LATCH;
    end
    else
    begin
      if (wr_a_data)
      begin
        latch_a <= REG_WDATA[PA_WIDTH-1:0]; // see [RULE18]
      end
      if (wr_b_data)
      begin
        latch_b <= REG_WDATA[PB_WIDTH-1:0]; // see [RULE18]
      end
    end
  end

  // Direction registers reset to all inputs.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      dir_a <= RST_BANK_A_DIR;
      dir_b <= RST_BANK_B_DIR;
    end
    else
    begin
      if (wr_a_dir)
      begin
        dir_a <= REG_WDATA[PA_WIDTH-1:0]; // see [RULE19]
      end
      if (wr_b_dir)
      begin
        dir_b <= REG_WDATA[PB_WIDTH-1:0]; // see [RULE1]
      end
    end
  end

  // Option reset leaves pull-ups disabled.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      option_ctl <= RST_OPTION; // see [RULE5]
    end
    else if (wr_option)
    begin
      option_ctl <= REG_WDATA;
    end
  end

  // Analog configuration resets to all analog; unused bits stay zero.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      conv_cfg <= RST_CONVERTER_CONFIG; // see [RULE20]
    end
    else if (wr_conv)
    begin
      conv_cfg <= REG_WDATA & CONVERTER_CONFIG_MASK;
    end
  end

  // Low-voltage programming mode, on after reset.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      lvp_mode <= RST_LVP; // see [RULE14]
    end
    else if (wr_misc)
    begin
      lvp_mode <= REG_WDATA[BIT_LVP];
    end
  end

  // Interrupt enables and edge flag.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      chg_en <= 1'b0;
      ext_en <= 1'b0;
      ext_flag <= 1'b0;
    end
    else
    begin
      if (wr_irq)
      begin
        chg_en <= REG_WDATA[BIT_CHANGE_IRQ_EN];
        ext_en <= REG_WDATA[BIT_EXT_IRQ_EN];
      end
      ext_flag <= next_ext_flag; // see [RULE13]
    end
  end

  // The previous pin level tracks the pin even while reset is held.
  // A pin that idles high therefore shows no false edge when reset is released.
  always_ff @(posedge REF_CLK)
  begin
    ext_pin_prev <= ext_level; // see [RULE13]
  end
endmodule : gpc_port_top

// ---- verif/gpc_port_props.sv ----
// Purpose: Concurrent checks on the ports of the dual port I/O block.
// Assumes: One clock domain on REF_CLK with synchronous active high reset.
// Notes: Bound into every instance of the top module.
module gpc_port_props
  import gpc_pkg::*;
#(
  parameter int PA_WIDTH = PA_W,
  parameter int PB_WIDTH = PB_W
)
(
  input wire logic REF_CLK, // Clock.
  input wire logic SYS_RST, // Reset.
  input wire logic [ADDR_W-1:0] REG_ADDR, // Address.
  input wire logic [DATA_W-1:0] REG_WDATA, // Write data.
  input wire logic REG_WR, // Write strobe.
  input wire logic REG_RD, // Read strobe.
  input wire logic [DATA_W-1:0] REG_RDATA, // Read data.
  input wire logic [PA_WIDTH-1:0] PA_IN, // Port A pins.
  input wire logic [PA_WIDTH-1:0] PA_OUT, // Port A drive.
  input wire logic [PB_WIDTH-1:0] PB_OUT, // Port B drive.
  input wire logic [PB_WIDTH-1:0] PB_OE_N, // Port B enables.
  input wire logic [PB_WIDTH-1:0] PB_PULLUP, // Port B pull-ups.
  input wire logic TIMER_CLK_IN, // Timer clock pin.
  input wire logic LVP_ACTIVE, // Programming mode.
  input wire logic SLEEP_ACTIVE, // Sleep state.
  input wire logic CHANGE_IRQ, // Change interrupt.
  input wire logic EXT_IRQ, // Edge interrupt.
  input wire logic WAKE // Wake request.
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  wire opt_wr = REG_WR && (REG_ADDR == OFS_OPTION || REG_ADDR == OFS_OPTION_ALT);
  wire dir_wr = REG_WR && (REG_ADDR == OFS_BANK_B_DIR || REG_ADDR == OFS_BANK_B_DIR_ALT);
  wire dat_wr = REG_WR && (REG_ADDR == OFS_BANK_B_DATA || REG_ADDR == OFS_BANK_B_DATA_ALT);

  a_rdata_idle_zero: assert property (!REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data not zero outside a read");
  a_dir_write_enables: assert property (
    dir_wr |=> (PB_OE_N | 8'h08) == ($past(REG_WDATA) | 8'h08))
    else $error("port B enables do not follow direction write");
  a_latch_write_drive: assert property (dat_wr |=> PB_OUT == $past(REG_WDATA))
    else $error("port B drive does not follow latch write");
  a_pullup_outputs_off: assert property ((PB_PULLUP & ~PB_OE_N) == 8'h00)
    else $error("pull-up on for a driven pin");
  a_pullup_global_ctl: assert property (opt_wr |=>
    PB_PULLUP == (PB_OE_N & {4'hF, ~LVP_ACTIVE, 3'h7} & {8{~$past(REG_WDATA[7])}}))
    else $error("pull-ups do not follow global control");
  a_reset_pullups_off: assert property ($fell(SYS_RST) |-> PB_PULLUP == 8'h00 && PB_OE_N == 8'hFF)
    else $error("pull-ups or enables wrong after reset");
  a_wake_from_sleep: assert property (WAKE == (SLEEP_ACTIVE && (CHANGE_IRQ || EXT_IRQ)))
    else $error("wake request wrong");
  a_open_drain_pin: assert property (PA_OUT[4] == 1'b0 && TIMER_CLK_IN == PA_IN[4])
    else $error("open drain pin drives high or timer input wrong");
  a_lvp_owns_pin: assert property (LVP_ACTIVE |-> PB_OE_N[3] && !PB_PULLUP[3])
    else $error("programming pin not released while mode on");
  a_dir_a_upper_zero: assert property (
    REG_RD && REG_ADDR == OFS_BANK_A_DIR |=> REG_RDATA[7:6] == 2'b00)
    else $error("port A direction upper bits not zero");
endmodule : gpc_port_props

bind gpc_port_top gpc_port_props #(.PA_WIDTH(PA_WIDTH), .PB_WIDTH(PB_WIDTH)) u_props (.REF_CLK(REF_CLK),
  .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .PA_IN(PA_IN), .PA_OUT(PA_OUT), .PB_OUT(PB_OUT), .PB_OE_N(PB_OE_N),
  .PB_PULLUP(PB_PULLUP), .TIMER_CLK_IN(TIMER_CLK_IN), .LVP_ACTIVE(LVP_ACTIVE), .SLEEP_ACTIVE(SLEEP_ACTIVE),
  .CHANGE_IRQ(CHANGE_IRQ), .EXT_IRQ(EXT_IRQ), .WAKE(WAKE));

// ---- verif/gpc_pin_model.sv ----
// Purpose: Board side of both ports: external drivers, pull-ups and floating pins.
// Assumes: The design drives a pin whenever its enable is low.
// Notes: A pin nobody drives or pulls shows the inverse of the level it last had while driven or pulled.
module gpc_pin_model
  import gpc_pkg::*;
(
  input wire logic clk, // Clock for the floating pattern.
  input wire logic [PA_W-1:0] pa_out, // Port A drive values.
  input wire logic [PA_W-1:0] pa_oe_n, // Port A enables.
  input wire logic [PB_W-1:0] pb_out, // Port B drive values.
  input wire logic [PB_W-1:0] pb_oe_n, // Port B enables.
  input wire logic [PB_W-1:0] pb_pullup, // Port B pull-ups.
  input wire logic [PA_W-1:0] ext_a, // Board levels on port A.
  input wire logic [PA_W-1:0] ext_a_en, // Board drives port A.
  input wire logic [PB_W-1:0] ext_b, // Board levels on port B.
  input wire logic [PB_W-1:0] ext_b_en, // Board drives port B.
  output logic [PA_W-1:0] pa_in, // Port A wire levels.
  output logic [PB_W-1:0] pb_in // Port B wire levels.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [PA_W-1:0] held_a;
  logic [PB_W-1:0] held_b;
  // Remembers each pin's level while something drives or pulls it.
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < PA_W; i++)
      if (!pa_oe_n[i] || ext_a_en[i])
        held_a[i] <= pa_in[i];
    for (int i = 0; i < PB_W; i++)
      if (!pb_oe_n[i] || ext_b_en[i] || pb_pullup[i])
        held_b[i] <= pb_in[i];
  end
  always_comb
  begin
    for (int i = 0; i < PA_W; i++)
      pa_in[i] = !pa_oe_n[i] ? pa_out[i] : ext_a_en[i] ? ext_a[i] : !held_a[i];
    for (int i = 0; i < PB_W; i++)
      pb_in[i] = !pb_oe_n[i] ? pb_out[i] : ext_b_en[i] ? ext_b[i] : pb_pullup[i] ? 1'b1 : !held_b[i];
  end
endmodule : gpc_pin_model

// ---- verif/dual_gpio_port_with_change_irq_tb_top.sv ----
// Purpose: Self-checking bench for the dual port I/O block.
// Assumes: Register master and board model as described for the block.
// Notes: Each scenario is one task and judges its own results.
module dual_gpio_port_with_change_irq_tb_top
  import gpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic REF_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [ADDR_W-1:0] REG_ADDR = '0;
  logic [DATA_W-1:0] REG_WDATA = '0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic SLEEP_ACTIVE = 1'b0;
  logic [PA_W-1:0] ext_a = 6'h3F;
  logic [PB_W-1:0] ext_b = 8'h00;
  logic [PB_W-1:0] ext_b_en = 8'hFF;
  logic [DATA_W-1:0] REG_RDATA;
  logic [PA_W-1:0] PA_IN, PA_OUT, PA_OE_N;
  logic [PB_W-1:0] PB_IN, PB_OUT, PB_OE_N, PB_PULLUP;
  logic TIMER_CLK_IN, LVP_ACTIVE, CHANGE_IRQ, EXT_IRQ, WAKE, PROG_PIN_IN;
  int mismatches = 0;
  int check_count = 0;

  always #10 REF_CLK = ~REF_CLK;

  gpc_port_top dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PA_IN(PA_IN), .PA_OUT(PA_OUT),
    .PA_OE_N(PA_OE_N), .PB_IN(PB_IN), .PB_OUT(PB_OUT), .PB_OE_N(PB_OE_N), .PB_PULLUP(PB_PULLUP),
    .TIMER_CLK_IN(TIMER_CLK_IN), .PROG_PIN_IN(PROG_PIN_IN), .LVP_ACTIVE(LVP_ACTIVE), .SLEEP_ACTIVE(SLEEP_ACTIVE),
    .CHANGE_IRQ(CHANGE_IRQ), .EXT_IRQ(EXT_IRQ), .WAKE(WAKE));
  gpc_pin_model pins (.clk(REF_CLK), .pa_out(PA_OUT), .pa_oe_n(PA_OE_N), .pb_out(PB_OUT),
    .pb_oe_n(PB_OE_N), .pb_pullup(PB_PULLUP), .ext_a(ext_a), .ext_a_en(6'h3F), .ext_b(ext_b),
    .ext_b_en(ext_b_en), .pa_in(PA_IN), .pb_in(PB_IN));

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA & mask, exp);
  endtask : rd

  task automatic t_reset();
    rd(OFS_OPTION, 8'hFF, 8'hFF);
    rd(OFS_BANK_B_DIR, 8'hFF, 8'hFF);
    rd(OFS_BANK_A_DIR, 8'hFF, 8'h3F);
    rd(9'h0_000, 8'hFF, 8'h00);
    chk(PB_PULLUP, 8'h00);
    chk({7'h00, LVP_ACTIVE}, 8'h01);
  endtask : t_reset

  task automatic t_pullups();
    ext_b_en <= 8'h00;
    wr(OFS_OPTION_ALT, 8'h7F);
    chk(PB_PULLUP, 8'hF7);
    rd(OFS_BANK_B_DATA, 8'hFF, 8'hF7);
    wr(OFS_BANK_B_DIR_ALT, 8'h0F);
    chk(PB_PULLUP, 8'h07);
    wr(OFS_OPTION, 8'hFF);
    chk(PB_PULLUP, 8'h00);
    ext_b_en <= 8'hFF;
  endtask : t_pullups

  task automatic t_drive();
    ext_b <= 8'h5A;
    wr(OFS_BANK_B_DIR, 8'h00);
    wr(OFS_BANK_B_DATA_ALT, 8'h5A);
    chk(PB_OUT, 8'h5A);
    chk(PB_OE_N, 8'h08);
    chk({7'h00, PROG_PIN_IN}, 8'h01);
    rd(OFS_BANK_B_DATA_ALT, 8'hFF, 8'h52);
    wr(OFS_MISC_CONTROL, 8'h00);
    chk(PB_OE_N, 8'h00);
    rd(OFS_BANK_B_DATA, 8'hFF, 8'h5A);
  endtask : t_drive

  task automatic t_bank_a_pin_data();
    wr(OFS_BANK_A_DIR, 8'hFF);
    rd(OFS_BANK_A_DIR, 8'hFF, 8'h3F);
    rd(OFS_BANK_A_DATA, 8'hFF, 8'h10);
    wr(OFS_CONVERTER_CONFIG, 8'h06);
    rd(OFS_BANK_A_DATA, 8'hFF, 8'h3F);
    wr(OFS_BANK_A_DATA, 8'h00);
    wr(OFS_BANK_A_DIR, 8'h2F);
    chk({2'b00, PA_OE_N}, 8'h2F);
    chk({7'h00, TIMER_CLK_IN}, 8'h00);
    wr(OFS_BANK_A_DATA, 8'h35);
    chk({2'b00, PA_OE_N}, 8'h3F);
    chk({2'b00, PA_OUT}, 8'h25);
    chk({7'h00, TIMER_CLK_IN}, 8'h01);
  endtask : t_bank_a_pin_data

  task automatic t_change();
    ext_b <= 8'h00;
    wr(OFS_BANK_B_DIR, 8'hFF);
    rd(OFS_BANK_B_DATA, 8'hFF, 8'h00);
    wr(OFS_IRQ_CONTROL, 8'h08);
    rd(OFS_IRQ_CONTROL, 8'h01, 8'h00);
    ext_b <= 8'h04;
    rd(OFS_IRQ_CONTROL, 8'h01, 8'h00);
    ext_b <= 8'h24;
    rd(OFS_IRQ_CONTROL, 8'h01, 8'h01);
    chk({7'h00, CHANGE_IRQ}, 8'h01);
    SLEEP_ACTIVE <= 1'b1;
    @(posedge REF_CLK);
    #1;
    chk({7'h00, WAKE}, 8'h01);
    SLEEP_ACTIVE <= 1'b0;
    wr(OFS_IRQ_CONTROL, 8'h08);
    rd(OFS_IRQ_CONTROL, 8'h01, 8'h01);
    rd(OFS_BANK_B_DATA, 8'hFF, 8'h24);
    wr(OFS_IRQ_CONTROL, 8'h08);
    rd(OFS_IRQ_CONTROL, 8'h01, 8'h00);
    wr(OFS_BANK_B_DATA, 8'hDA);
    wr(OFS_BANK_B_DIR, 8'h7F);
    rd(OFS_IRQ_CONTROL, 8'h01, 8'h00);
  endtask : t_change

  task automatic t_edge_irq();
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_OPTION, k ? 8'hBF : 8'hFF);
      ext_b[0] <= k[0];
      repeat (3) @(posedge REF_CLK);
      wr(OFS_IRQ_CONTROL, 8'h10);
      rd(OFS_IRQ_CONTROL, 8'h02, 8'h00);
      ext_b[0] <= ~k[0];
      rd(OFS_IRQ_CONTROL, 8'h02, 8'h02);
      chk({7'h00, EXT_IRQ}, 8'h01);
      wr(OFS_IRQ_CONTROL, 8'h10);
      ext_b[0] <= k[0];
      rd(OFS_IRQ_CONTROL, 8'h02, 8'h00);
    end
  endtask : t_edge_irq

  initial
  begin
    repeat (12) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    t_reset();
    t_pullups();
    t_drive();
    t_bank_a_pin_data();
    t_change();
    t_edge_irq();
    summarize();
  end

  initial
  begin
    repeat (5000) @(posedge REF_CLK);
    mismatches++;
    summarize();
  end
endmodule : dual_gpio_port_with_change_irq_tb_top
